// File: logic/fpw_timer.sv
`timescale 1ns/100ps
// Operation
// - Two compare registers match the same counter, each with own irq.
// - Free-run capture latches count on own trigger, counter untouched.
// - One wrap flag shared by both capture channels.
// - Wrap flag shows at least one wrap, never a count.
// - Wrap flag clears by byte write to option with bit 0 low.
// - Capture right after start may latch ffff, the stopped value.
// - Mode 110 selects pulse-width mode; count enable starts counting.
// - Pulse-width edge captures count, clears counter, raises capture irq.
// - Pulse-width wrap past ffff raises irq, sets flag, restarts at zero.
// - Pulse-width mode uses both registers as capture only.
// - Pulse-width mode ignores output control; trigger-edge register still selects capture edges.
// - Counter read buffer returns present counter value, or zero while stopped.
// - Mode 101 selects free-running; count enable starts counting.
// - Option select bit chooses compare or capture per register.
// - Free-run start inverts both outputs; each match inverts its own output.
// - Compare writes take effect at once while running.
module fpw_timer #(
  parameter int NCH = 2
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic clk_en_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [fpw_pkg::AW-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [fpw_pkg::DW-1:0] wb_dat_i,
  output logic [fpw_pkg::DW-1:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic [NCH-1:0] capture_trigger_input_i,
  output logic [NCH-1:0] timer_output_pin_o,
  output logic [NCH-1:0] channel_match_capture_irq_o,
  output logic counter_wrap_irq_o
);
  import fpw_pkg::*;

  fpw_state_t state_q;
  logic [7:0] ctl0_q;
  logic [7:0] ctl1_q;
  logic [7:0] ioc0_q;
  logic [7:0] ioc1_q;
  logic [7:0] ioc2_q;
  logic [NCH-1:0] ccs_q;
  logic wrap_flag_q;
  logic [CW-1:0] cnt_q;
  logic [DIVW-1:0] div_q;
  logic [NCH-1:0][CW-1:0] ccr_q;
  logic [NCH-1:0] trig_prev_q;
  logic [NCH-1:0] toggle_q;
  logic [NCH-1:0] irq_q;
  logic wrap_irq_q;
  logic ack_q;
  logic [DW-1:0] rdat_q;

  logic acc;
  logic wr;
  logic [MODEW-1:0] mode;
  logic fr_mode;
  logic pw_mode;
  logic go;
  logic start;
  logic tick;
  logic [DIVW-1:0] div_mask;
  logic [NCH-1:0] cap_hit;
  logic [NCH-1:0] match_hit;
  logic pw_clear;
  logic wrap_hit;
  logic wrap_clr;
  logic [DW-1:0] rmux;

  assign acc = wb_cyc_i & wb_stb_i & ~ack_q;
  assign wr = acc & wb_we_i;
  assign mode = ctl1_q[CTL1_MODE_LSB +: MODEW];
  assign pw_mode = (mode == MODE_PWM);
  assign fr_mode = (mode == MODE_FREE);
  // Modes outside these two are not built here, so the counter stays idle.
  assign go = ctl0_q[CTL0_CE_BIT] & (fr_mode | pw_mode);
  assign start = (state_q == FPW_STOP) & go;

  // The count clock is the system clock divided by a power of two.
  assign div_mask = (DIV_ONE << ctl0_q[CTL0_CKS_LSB +: CKSW]) - DIV_ONE;
  assign tick = (state_q != FPW_STOP) & ((div_q & div_mask) == div_mask);

  assign pw_clear = pw_mode & (|cap_hit);
  assign wrap_hit = tick & (state_q == FPW_RUN) & (cnt_q == CNT_MAX)
    & go & ~pw_clear;
  assign wrap_clr = wr & (wb_adr_i == OFS_OPT0) & wb_sel_i[0]
    & ~wb_dat_i[OPT0_WRAP_BIT];

  genvar m;
  generate
    for (m = 0; m < NCH; m++)
    begin : g_ch
      logic rise;
      logic fall;
      logic [1:0] esel;
      logic [AW-1:0] ccr_ofs;
      assign ccr_ofs = OFS_CCRA + AW'(4 * m);
      assign esel = ioc1_q[IOC1_EDGE_W*m +: IOC1_EDGE_W];
      assign rise = capture_trigger_input_i[m] & ~trig_prev_q[m];
      assign fall = ~capture_trigger_input_i[m] & trig_prev_q[m];
      // per-register capture select in free-run; every register captures in pw mode
      assign cap_hit[m] = (state_q != FPW_STOP) & go
        & (pw_mode | (fr_mode & ccs_q[m]))
        & ((rise & (esel == EDGE_RISE || esel == EDGE_BOTH))
        | (fall & (esel == EDGE_FALL || esel == EDGE_BOTH)));
      assign match_hit[m] = tick & (state_q == FPW_RUN) & go & fr_mode
        & ~ccs_q[m] & (cnt_q == ccr_q[m]);

      always_ff @(posedge clk_i)
      begin
        if (rst_i)
        begin
          ccr_q[m] <= CCR_RST;
        end
        else if (clk_en_i)
        begin
          if (cap_hit[m])
          begin
            ccr_q[m] <= cnt_q;
          end
          else if (wr && wb_adr_i == ccr_ofs)
          begin
            if (wb_sel_i[0])
            begin
              ccr_q[m][7:0] <= wb_dat_i[7:0];
            end
            if (wb_sel_i[1])
            begin
              ccr_q[m][15:8] <= wb_dat_i[15:8];
            end
          end
        end
      end

      always_ff @(posedge clk_i)
      begin
        if (rst_i)
        begin
          toggle_q[m] <= 1'b0;
          trig_prev_q[m] <= 1'b0;
          irq_q[m] <= 1'b0;
        end
        else if (clk_en_i)
        begin
          trig_prev_q[m] <= capture_trigger_input_i[m];
          irq_q[m] <= cap_hit[m] | match_hit[m];
          // invert on start and on match
          if ((start & fr_mode) | match_hit[m])
          begin
            toggle_q[m] <= ~toggle_q[m];
          end
        end
      end

      // output control has no effect in pulse-width mode
      assign timer_output_pin_o[m] = toggle_q[m] & ioc0_q[m] & fr_mode;
    end
  endgenerate

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      state_q <= FPW_STOP;
      cnt_q <= CNT_MAX;
    end
    else if (clk_en_i)
    begin
      case (state_q)
        FPW_STOP:
        begin
          cnt_q <= CNT_MAX;
          if (go)
          begin
            state_q <= FPW_ARMED;
          end
        end
        FPW_ARMED:
        begin
          // counter still holds ffff until the first count clock or pulse-width edge
          if (!go)
          begin
            state_q <= FPW_STOP;
          end
          else if (pw_clear || tick)
          begin
            cnt_q <= CNT_ZERO;
            state_q <= FPW_RUN;
          end
        end
        FPW_RUN:
        begin
          if (!go)
          begin
            cnt_q <= CNT_MAX;
            state_q <= FPW_STOP;
          end
          else if (pw_clear)
          begin
            cnt_q <= CNT_ZERO;
          end
          // free-run captures leave the count alone
          else if (tick)
          begin
            cnt_q <= cnt_q + 16'h0001;
          end
        end
        default:
        begin
          state_q <= FPW_STOP;
          cnt_q <= CNT_MAX;
        end
      endcase
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      div_q <= '0;
    end
    else if (clk_en_i)
    begin
      if (state_q == FPW_STOP)
      begin
        div_q <= '0;
      end
      else
      begin
        div_q <= div_q + DIV_ONE;
      end
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      wrap_flag_q <= 1'b0;
      wrap_irq_q <= 1'b0;
    end
    else if (clk_en_i)
    begin
      wrap_irq_q <= wrap_hit;
      // one shared flag; set again stays simply set
      if (wrap_hit)
      begin
        wrap_flag_q <= 1'b1;
      end
      else if (wrap_clr)
      begin
        wrap_flag_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ctl0_q <= CTL_RST;
      ctl1_q <= CTL_RST;
      ioc0_q <= CTL_RST;
      ioc1_q <= CTL_RST;
      ioc2_q <= CTL_RST;
      ccs_q <= '0;
    end
    else if (clk_en_i && wr && wb_sel_i[0])
    begin
      case (wb_adr_i)
        OFS_CTL0: ctl0_q <= wb_dat_i[7:0];
        OFS_CTL1: ctl1_q <= wb_dat_i[7:0];
        OFS_IOC0: ioc0_q <= wb_dat_i[7:0];
        OFS_IOC1: ioc1_q <= wb_dat_i[7:0];
        OFS_IOC2: ioc2_q <= wb_dat_i[7:0];
        OFS_OPT0: ccs_q <= wb_dat_i[OPT0_CCS_LSB +: NCH];
        default: ctl0_q <= ctl0_q;
      endcase
    end
  end

  always_comb
  begin
    rmux = '0;
    case (wb_adr_i)
      OFS_CTL0: rmux[7:0] = ctl0_q;
      OFS_CTL1: rmux[7:0] = ctl1_q;
      OFS_IOC0: rmux[7:0] = ioc0_q;
      OFS_IOC1: rmux[7:0] = ioc1_q;
      OFS_IOC2: rmux[7:0] = ioc2_q;
      OFS_OPT0:
      begin
        rmux[OPT0_CCS_LSB +: NCH] = ccs_q;
        rmux[OPT0_WRAP_BIT] = wrap_flag_q;
      end
      OFS_CCRA: rmux[CW-1:0] = ccr_q[0];
      OFS_CCRB: rmux[CW-1:0] = ccr_q[1];
      // present count; a stopped counter reads as zero
      OFS_CNT: rmux[CW-1:0] = (state_q == FPW_STOP) ? CNT_ZERO : cnt_q;
      default: rmux = '0;
    endcase
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ack_q <= 1'b0;
      rdat_q <= '0;
    end
    else if (clk_en_i)
    begin
      ack_q <= acc;
      if (acc)
      begin
        rdat_q <= rmux;
      end
    end
  end

  assign wb_ack_o = ack_q;
  assign wb_dat_o = rdat_q;
  assign channel_match_capture_irq_o = irq_q;
  assign counter_wrap_irq_o = wrap_irq_q;

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  sequence s_cnt_read;
    clk_en_i && acc && !wb_we_i && wb_adr_i == OFS_CNT
      && state_q == FPW_RUN;
  endsequence

  sequence s_wrap_event;
    clk_en_i && wrap_hit;
  endsequence

  a_wb_ack_pulse: assert property (clk_en_i && wb_ack_o |=> !wb_ack_o)
    else $error("ack held longer than one cycle");
  a_match_irq_a: assert property (
    clk_en_i && match_hit[0] |=> irq_q[0]
      && toggle_q[0] != $past(toggle_q[0]))
    else $error("match did not raise irq and invert output a");
  a_capture_free_latch: assert property (
    clk_en_i && cap_hit[1] |=> ccr_q[1] == $past(cnt_q) && irq_q[1])
    else $error("capture b did not latch the count");
  a_free_no_clear: assert property (
    clk_en_i && fr_mode && go && state_q == FPW_RUN && cap_hit[0]
      |=> cnt_q == CW'($past(cnt_q) + $past(tick)))
    else $error("free-run capture disturbed the counter");
  a_wrap_sets_flag: assert property (
    s_wrap_event |=> wrap_flag_q && counter_wrap_irq_o
      && cnt_q == CNT_ZERO)
    else $error("wrap did not set flag, irq and zero count");
  a_flag_clear_write: assert property (
    clk_en_i && wrap_clr && !wrap_hit |=> !wrap_flag_q)
    else $error("wrap flag not cleared by option write");
  a_flag_set_wins: assert property (
    clk_en_i && wrap_clr && wrap_hit |=> wrap_flag_q)
    else $error("clear overrode a simultaneous wrap");
  a_pw_capture_clear: assert property (
    clk_en_i && pw_mode && |cap_hit |=> cnt_q == CNT_ZERO
      && (irq_q & $past(cap_hit)) == $past(cap_hit))
    else $error("pulse-width edge did not clear and interrupt");
  a_cnt_read_value: assert property (
    s_cnt_read |=> wb_ack_o && wb_dat_o[CW-1:0] == $past(cnt_q))
    else $error("counter read returned wrong value");
  a_armed_holds_ffff: assert property (
    state_q == FPW_ARMED |-> cnt_q == CNT_MAX)
    else $error("counter left ffff before first count clock");
  a_start_inverts: assert property (
    clk_en_i && start && fr_mode |=> toggle_q == ~$past(toggle_q))
    else $error("start did not invert both outputs");
  a_disable_stops: assert property (
    clk_en_i && !go |=> state_q == FPW_STOP)
    else $error("counter did not stop when disabled");
endmodule : fpw_timer

// File: include/fpw_pkg.sv
package fpw_pkg;
  localparam int CW = 16;
  localparam int AW = 8;
  localparam int DW = 32;
  localparam int DIVW = 8;
  localparam int CKSW = 3;
  localparam int MODEW = 3;

  // Register byte addresses.
  localparam logic [AW-1:0] OFS_CTL0 = 8'h00;
  localparam logic [AW-1:0] OFS_CTL1 = 8'h04;
  localparam logic [AW-1:0] OFS_IOC0 = 8'h08;
  localparam logic [AW-1:0] OFS_IOC1 = 8'h0c;
  localparam logic [AW-1:0] OFS_IOC2 = 8'h10;
  localparam logic [AW-1:0] OFS_OPT0 = 8'h14;
  localparam logic [AW-1:0] OFS_CCRA = 8'h18;
  localparam logic [AW-1:0] OFS_CCRB = 8'h1c;
  localparam logic [AW-1:0] OFS_CNT = 8'h20;

  // Field positions.
  localparam int CTL0_CE_BIT = 7;
  localparam int CTL0_CKS_LSB = 0;
  localparam int CTL1_MODE_LSB = 0;
  localparam int OPT0_WRAP_BIT = 0;
  localparam int OPT0_CCS_LSB = 4;
  localparam int IOC1_EDGE_W = 2;

  // Reset values.
  localparam logic [7:0] CTL_RST = 8'h00;
  localparam logic [CW-1:0] CCR_RST = 16'h0000;

  // Mode field codes.
  localparam logic [MODEW-1:0] MODE_FREE = 3'b101;
  localparam logic [MODEW-1:0] MODE_PWM = 3'b110;

  // Edge selection codes.
  localparam logic [1:0] EDGE_RISE = 2'h1;
  localparam logic [1:0] EDGE_FALL = 2'h2;
  localparam logic [1:0] EDGE_BOTH = 2'h3;

  localparam logic [CW-1:0] CNT_MAX = 16'hffff;
  localparam logic [CW-1:0] CNT_ZERO = 16'h0000;
  localparam logic [DIVW-1:0] DIV_ONE = 8'h01;

  typedef enum logic [1:0] {
    FPW_STOP,
    FPW_ARMED,
    FPW_RUN
  } fpw_state_t;
endpackage : fpw_pkg

// File: tb/fpw_trig_model.sv
`timescale 1ns/100ps
// Stands in for the external pulse sources on the two trigger pins.
// Each request toggles its pin once, so two requests make one pulse.
// Pins start low, as a pulled-down line would before any source drives.
module fpw_trig_model (
  input wire logic clk_i,
  input wire logic [1:0] flip_i,
  output logic [1:0] trig_o
);
  initial trig_o = 2'b00;
  always @(posedge clk_i)
  begin
    trig_o <= trig_o ^ flip_i;
  end
endmodule : fpw_trig_model

// File: tb/tb_top.sv
`timescale 1ns/100ps
module tb_top;
  import fpw_pkg::*;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [AW-1:0] adr = 8'h00;
  logic [3:0] sel = 4'h3;
  logic [DW-1:0] dat = 32'h0;
  logic [DW-1:0] dat_o;
  logic ack;
  logic [1:0] flip = 2'b00;
  logic [1:0] trig;
  logic [1:0] pins;
  logic [1:0] irq;
  logic wrap;
  logic [DW-1:0] rv;
  int bad_count = 0;
  int n_checks = 0;

  fpw_trig_model i_trig (.clk_i(clk_i), .flip_i(flip), .trig_o(trig));
  fpw_timer i_dut (.clk_i(clk_i), .rst_i(rst_i), .clk_en_i(1'b1),
    .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(dat_o), .wb_ack_o(ack),
    .capture_trigger_input_i(trig), .timer_output_pin_o(pins),
    .channel_match_capture_irq_o(irq), .counter_wrap_irq_o(wrap));

  initial
  begin
    forever #10 clk_i = ~clk_i;
  end

  task automatic complete_run();
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : complete_run

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      bad_count++;
      $display("mismatch at %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // Ack is read in the active region of the edge, so it is the sampled value.
  task automatic wb(input logic w, input logic [7:0] a,
                    input logic [31:0] d, output logic [31:0] r);
    int n;
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dat <= d;
    n = 0;
    do
    begin
      @(posedge clk_i);
      n++;
    end while (ack !== 1'b1 && n < 20);
    if (n >= 20)
      bad_count++;
    r = dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask : wb

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    wb(1'b1, a, d, rv);
  endtask : wr

  task automatic rd(input logic [7:0] a);
    wb(1'b0, a, 32'h0, rv);
  endtask : rd

  task automatic pulse(input logic [1:0] m);
    @(posedge clk_i);
    flip <= m;
    @(posedge clk_i);
    flip <= 2'b00;
  endtask : pulse

  task automatic t_reset();
    rd(OFS_CTL0);
    chk(rv, 32'h0);
    rd(OFS_CCRA);
    chk(rv, 32'h0);
    rd(OFS_OPT0);
    chk(rv, 32'h0);
    rd(OFS_CNT);
    chk(rv, 32'h0);
    rd(8'h40);
    chk(rv, 32'h0);
  endtask : t_reset

  task automatic t_compare();
    int ia;
    int ib;
    ia = 0;
    ib = 0;
    // Interval of three, loaded minus one.
    wr(OFS_CCRA, 32'h2);
    wr(OFS_CCRB, 32'h5);
    wr(OFS_IOC0, 32'h3);
    wr(OFS_CTL1, {29'h0, MODE_FREE});
    wr(OFS_CTL0, 32'h80);
    for (int i = 1; i <= 12; i++)
    begin
      @(negedge clk_i);
      if (i == 1)
        chk(pins, 2'b11);
      if (irq[0] === 1'b1)
        ia = i;
      if (irq[1] === 1'b1)
        ib = i;
    end
    chk(ia, 5);
    chk(ib, 8);
    chk(pins, 2'b00);
    // New compare value while running; the count is 12 as it lands.
    ib = 0;
    wr(OFS_CCRB, 32'h14);
    for (int i = 1; i <= 12; i++)
    begin
      @(negedge clk_i);
      if (irq[1] === 1'b1)
        ib = i;
    end
    chk(ib, 9);
    chk(pins, 2'b10);
    wr(OFS_CTL0, 32'h0);
  endtask : t_compare

  task automatic t_fcapture();
    logic [31:0] a;
    logic [31:0] b;
    wr(OFS_OPT0, 32'h30);
    wr(OFS_IOC1, 32'h5);
    wr(OFS_CTL0, 32'h80);
    repeat (3) @(posedge clk_i);
    pulse(2'b01);
    repeat (8) @(posedge clk_i);
    pulse(2'b10);
    repeat (4) @(posedge clk_i);
    rd(OFS_CCRA);
    a = rv;
    rd(OFS_CCRB);
    b = rv;
    rd(OFS_CNT);
    chk(b - a, 32'ha);
    chk(rv > b, 1);
    // Period from two successive reads of one register.
    pulse(2'b01);
    pulse(2'b01);
    rd(OFS_CCRA);
    chk(rv - a, 32'h1b);
    wr(OFS_CTL0, 32'h0);
  endtask : t_fcapture

  task automatic t_pwidth();
    pulse(2'b11);
    wr(OFS_CTL1, {29'h0, MODE_PWM});
    wr(OFS_OPT0, 32'h0);
    // Only trigger a captures; b is toggled but has no edge detection.
    wr(OFS_IOC1, 32'h1);
    wr(OFS_IOC2, 32'hff);
    wr(OFS_CTL0, 32'h80);
    repeat (3) @(posedge clk_i);
    pulse(2'b01);
    repeat (18) @(posedge clk_i);
    pulse(2'b11);
    pulse(2'b01);
    repeat (4) @(posedge clk_i);
    chk(pins, 2'b00);
    rd(OFS_CCRA);
    chk(rv, 32'h15);
    rd(OFS_CCRB);
    chk(rv, 32'he);
  endtask : t_pwidth

  task automatic t_wrap();
    int n;
    wr(OFS_IOC1, 32'h0);
    n = 0;
    while (wrap !== 1'b1 && n < 70000)
    begin
      @(negedge clk_i);
      n++;
    end
    chk(n < 70000, 1);
    rd(OFS_OPT0);
    chk(rv[0], 1'b1);
    wr(OFS_OPT0, 32'h1);
    rd(OFS_OPT0);
    chk(rv[0], 1'b1);
    wr(OFS_OPT0, 32'h0);
    rd(OFS_OPT0);
    chk(rv[0], 1'b0);
    rd(OFS_CNT);
    chk(rv < 32, 1);
  endtask : t_wrap

  initial
  begin
    repeat (90000) @(posedge clk_i);
    bad_count++;
    complete_run();
  end

  initial
  begin
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    t_reset();
    t_compare();
    t_fcapture();
    t_pwidth();
    t_wrap();
    complete_run();
  end
endmodule : tb_top
